// *** hw/sram_ctrl.v ***
// host-side controller driving an asynchronous 16-bit sram through its pins
`include "sram_ctrl_consts.vh"

module sram_ctrl #(
  parameter ADDR_W = `ADDR_W,
  parameter DATA_W = `DATA_W
) (
  input wire mclk,
  input wire rst,
  input wire req,
  input wire req_write,
  input wire [ADDR_W-1:0] req_addr,
  input wire [DATA_W-1:0] req_wdata,
  input wire [1:0] req_lanes,
  output reg req_ready,
  output reg rsp_valid,
  output reg [DATA_W-1:0] rsp_rdata,
  output reg [ADDR_W-1:0] mem_addr,
  output reg chip_select_n,
  output reg output_enable_n,
  output reg write_enable_n,
  output reg lower_byte_select_n,
  output reg upper_byte_select_n,
  input wire [DATA_W-1:0] mem_data_in,
  output reg [DATA_W-1:0] mem_data_out,
  output reg mem_data_oe
);
  // ****************************************************************
  // states and timer
  // ****************************************************************
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RSET = 3'h1;
  localparam [2:0] S_RWAIT = 3'h2;
  localparam [2:0] S_WSET = 3'h3;
  localparam [2:0] S_WPULSE = 3'h4;
  localparam [2:0] S_WEND = 3'h5;
  localparam [2:0] S_FLOAT = 3'h6;
  localparam integer READ_WAIT_I = `READ_WAIT_CYC;
  localparam integer WRITE_PULSE_I = `WRITE_PULSE_CYC;
  localparam integer FLOAT_WAIT_I = `FLOAT_CYC;
  // integer figures cut to the counter width on purpose
  localparam [`CNT_W-1:0] READ_WAIT = READ_WAIT_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] WRITE_PULSE = WRITE_PULSE_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] FLOAT_WAIT = FLOAT_WAIT_I[`CNT_W-1:0];

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg tmr_load;
  reg [`CNT_W-1:0] tmr_count;
  wire tmr_done;
  reg [1:0] lanes_q;

  cycle_timer #(.W(`CNT_W)) u_timer (
    .mclk(mclk),
    .rst(rst),
    .load(tmr_load),
    .count(tmr_count),
    .busy(),
    .done(tmr_done)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  // every wait is at least one 20 ns cycle, which covers the 15 ns cycle minimum
  always @*
  begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_count = {`CNT_W{1'b0}};
    case (state_q)
      S_IDLE:
      begin
        if (req && req_ready)
          state_d = req_write ? S_WSET : S_RSET;
      end
      S_RSET:
      begin
        tmr_load = 1'b1;
        tmr_count = READ_WAIT;
        state_d = S_RWAIT;
      end
      S_RWAIT:
      begin
        if (tmr_done)
        begin
          tmr_load = 1'b1;
          tmr_count = FLOAT_WAIT;
          state_d = S_FLOAT;
        end
      end
      S_WSET:
      begin
        tmr_load = 1'b1;
        tmr_count = WRITE_PULSE;
        state_d = S_WPULSE;
      end
      S_WPULSE:
      begin
        if (tmr_done)
          state_d = S_WEND;
      end
      S_WEND:
      begin
        tmr_load = 1'b1;
        tmr_count = FLOAT_WAIT;
        state_d = S_FLOAT;
      end
      S_FLOAT:
      begin
        if (tmr_done)
          state_d = S_IDLE;
      end
      default:
      begin
        state_d = S_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // state, pins and user port
  // ****************************************************************
  // all pins come from flops so no glitch reaches the async part
  always @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      lanes_q <= 2'h0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {DATA_W{1'b0}};
      mem_addr <= {ADDR_W{1'b0}};
      chip_select_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
      lower_byte_select_n <= 1'b1;
      upper_byte_select_n <= 1'b1;
      mem_data_out <= {DATA_W{1'b0}};
      mem_data_oe <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      rsp_valid <= 1'b0;
      req_ready <= (state_d == S_IDLE) && (state_q != S_IDLE || !req);
      case (state_q)
        S_IDLE:
        begin
          if (req && req_ready)
          begin
            // address moves only while all strobes are high
            mem_addr <= req_addr;
            lanes_q <= req_lanes;
            mem_data_out <= req_wdata;
          end
        end
        S_RSET:
        begin
          chip_select_n <= 1'b0;
          output_enable_n <= 1'b0;
          lower_byte_select_n <= ~lanes_q[0];
          upper_byte_select_n <= ~lanes_q[1];
          mem_data_oe <= 1'b0;
        end
        S_RWAIT:
        begin
          if (tmr_done)
          begin
            // sample while strobes still low; data valid past access time
            rsp_rdata <= mem_data_in;
            rsp_valid <= 1'b1;
            chip_select_n <= 1'b1;
            output_enable_n <= 1'b1;
            lower_byte_select_n <= 1'b1;
            upper_byte_select_n <= 1'b1;
          end
        end
        S_WSET:
        begin
          // select and the enabled lane strobes fall together with write enable; output enable stays high, so no read drive
          chip_select_n <= 1'b0;
          write_enable_n <= 1'b0;
          output_enable_n <= 1'b1;
          lower_byte_select_n <= ~lanes_q[0];
          upper_byte_select_n <= ~lanes_q[1];
          mem_data_oe <= 1'b1;
        end
        S_WPULSE:
        begin
          if (tmr_done)
          begin
            // all strobes rise together; address and data held after
            write_enable_n <= 1'b1;
            chip_select_n <= 1'b1;
            lower_byte_select_n <= 1'b1;
            upper_byte_select_n <= 1'b1;
          end
        end
        S_WEND:
        begin
          mem_data_oe <= 1'b0;
        end
        default:
        begin
        end
      endcase
    end
  end
endmodule // sram_ctrl

// *** hw/sram_ctrl_consts.vh ***
// timing constants and pin widths for the asynchronous sram controller
`ifndef SRAM_CTRL_CONSTS_VH
`define SRAM_CTRL_CONSTS_VH
// ****************************************************************
// clock and device timing, figures in ns (slow grade, safe for both)
// ****************************************************************
`define CLK_PERIOD_NS 20
`define READ_CYCLE_MIN_NS 15
`define ADDRESS_ACCESS_MAX_NS 15
`define CHIP_SELECT_ACCESS_MAX_NS 15
`define OUTPUT_ENABLE_VALID_MAX_NS 7
`define DESELECT_FLOAT_MAX_NS 7
`define WRITE_CYCLE_MIN_NS 15
`define WRITE_PULSE_MIN_NS 10
`define DATA_OVERLAP_MIN_NS 7
`define WRITE_RELEASE_DRIVE_MIN_NS 3
// least times round up, longest access waits also round up to be safe
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC ((`CYC_UP(`CHIP_SELECT_ACCESS_MAX_NS) < 1) ? 1 : `CYC_UP(`CHIP_SELECT_ACCESS_MAX_NS))
`define WRITE_PULSE_CYC ((`CYC_UP(`WRITE_PULSE_MIN_NS) < 1) ? 1 : `CYC_UP(`WRITE_PULSE_MIN_NS))
`define FLOAT_CYC ((`CYC_UP(`DESELECT_FLOAT_MAX_NS) < 1) ? 1 : `CYC_UP(`DESELECT_FLOAT_MAX_NS))
// ****************************************************************
// widths
// ****************************************************************
`define ADDR_W 18
`define DATA_W 16
`define CNT_W 4
`endif

// *** hw/cycle_timer.v ***
// down counter that pulses when a loaded wait has elapsed
module cycle_timer #(
  parameter W = 4
) (
  input wire mclk,
  input wire rst,
  input wire load,
  input wire [W-1:0] count,
  output reg busy,
  output reg done
);
  reg [W-1:0] cnt_q;
  // ****************************************************************
  // counter
  // ****************************************************************
  // done pulses one cycle after the last counted cycle
  always @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_q <= {W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (load)
    begin
      cnt_q <= count;
      busy <= 1'b1;
      done <= 1'b0;
    end
    else if (busy)
    begin
      if (cnt_q <= {{(W-1){1'b0}}, 1'b1})
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
      else
      begin
        done <= 1'b0;
      end
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
    else
    begin
      done <= 1'b0;
    end
  end
endmodule // cycle_timer

// *** test/sram_ctrl_asserts.sv ***
// pin timing assertions for the sram controller
module sram_ctrl_asserts (
  input wire mclk,
  input wire rst,
  input wire [17:0] mem_addr,
  input wire chip_select_n,
  input wire output_enable_n,
  input wire write_enable_n,
  input wire [15:0] mem_data_out,
  input wire mem_data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // write and read shape
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // select and write enable drop together, so the device never drives
  sequence wr_start_s;
    $fell(write_enable_n) && $fell(chip_select_n);
  endsequence
  sequence wr_pulse_s;
    !write_enable_n [*2] ##1 write_enable_n;
  endsequence
  addr_move_a: assert property ($changed(mem_addr) |-> write_enable_n || chip_select_n)
    else $error("address moved in write");
  wr_len_a: assert property (wr_start_s |-> wr_pulse_s)
    else $error("write pulse length");
  wr_setup_a: assert property ($fell(write_enable_n) |-> $fell(chip_select_n) && $stable(mem_addr))
    else $error("write start");
  data_valid_a: assert property (!write_enable_n |-> mem_data_oe && $stable(mem_data_out))
    else $error("write data moved");
  data_hold_a: assert property ($rose(write_enable_n) |-> mem_data_oe)
    else $error("write data hold");
  addr_hold_a: assert property ($rose(chip_select_n) |-> $stable(mem_addr))
    else $error("address hold");
  no_fight_a: assert property (!chip_select_n && !output_enable_n |-> !mem_data_oe)
    else $error("bus contention");
  read_mode_a: assert property (!output_enable_n |-> write_enable_n && !chip_select_n)
    else $error("read strobes");
endmodule // sram_ctrl_asserts

bind sram_ctrl sram_ctrl_asserts chk (.mclk, .rst, .mem_addr, .chip_select_n, .output_enable_n,
  .write_enable_n, .mem_data_out, .mem_data_oe);

// *** test/sram_model.sv ***
// behavioural sram with data bus resolution
module sram_model #(
  parameter int ACC = 15
) (
  input wire mclk,
  input wire [17:0] mem_addr,
  input wire chip_select_n,
  input wire output_enable_n,
  input wire write_enable_n,
  input wire lower_byte_select_n,
  input wire upper_byte_select_n,
  input wire [15:0] mem_data_out,
  input wire mem_data_oe,
  output logic [15:0] mem_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // array and drive
  // ****
  logic [15:0] mem [0:255];
  wire [1:0] lane = ~{upper_byte_select_n, lower_byte_select_n};
  wire rd = !chip_select_n && !output_enable_n && write_enable_n;
  wire #3 rd_lz = rd;
  wire #(ACC) rd_ok = rd;
  wire [1:0] drv = {2{rd & rd_lz}} & lane;
  // inverted word until access time has run, so early sampling shows
  // address seen late so the old word lingers after a move
  wire [7:0] #3 rd_addr = mem_addr[7:0];
  wire [15:0] q = rd_ok ? mem[rd_addr] : ~mem[rd_addr];
  initial foreach (mem[i]) mem[i] = 16'h0000;
  // write only while select, write enable and a lane overlap
  always @*
  begin
    if (!chip_select_n && !write_enable_n && lane[0])
      mem[mem_addr[7:0]][7:0] = mem_data_in[7:0];
    if (!chip_select_n && !write_enable_n && lane[1])
      mem[mem_addr[7:0]][15:8] = mem_data_in[15:8];
  end
  // a floating lane toggles at every clock edge so no stale value passes
  always @*
    for (int b = 0; b < 16; b++)
      mem_data_in[b] = mem_data_oe ? mem_data_out[b] : drv[b / 8] ? q[b] : b[0] ^ mclk;
endmodule // sram_model

// *** test/testbench.sv ***
// self-checking bench for the sram controller
`include "sram_ctrl_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // take edge, strobes out, access wait, then the sampling flop
  localparam int RD_LAT = `READ_WAIT_CYC + 3;
  logic mclk = 0;
  logic rst = 1;
  logic req = 0;
  logic req_write = 0;
  logic [17:0] req_addr = 0;
  logic [15:0] req_wdata = 0;
  logic [1:0] req_lanes = 0;
  wire req_ready, rsp_valid, mem_data_oe;
  wire chip_select_n, output_enable_n, write_enable_n, lower_byte_select_n, upper_byte_select_n;
  wire [15:0] rsp_rdata, mem_data_in, mem_data_out;
  wire [17:0] mem_addr;
  logic [15:0] ref_mem [0:255];
  int err_count = 0;
  int n_tests = 0;
  sram_ctrl dut (.*);
  sram_model #(.ACC(15)) ram (.*);
  always #10 mclk = ~mclk;
  // ****
  // helpers
  // ****
  function automatic [15:0] lane_mask(input [1:0] l);
    return {{8{l[1]}}, {8{l[0]}}};
  endfunction
  task automatic check(input string what, input [15:0] exp, input [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one request held until taken; a read compares only its lanes
  task automatic op(input bit w, input [17:0] a, input [15:0] d, input [1:0] l);
    int k;
    @(posedge mclk);
    req <= 1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lanes <= l;
    k = 0;
    do begin @(posedge mclk); k++; end while (req_ready !== 1'b1 && k < 20);
    req <= 0;
    check("ready wait", 16'h0001, 16'(k < 20));
    if (w)
      ref_mem[a[7:0]] = (ref_mem[a[7:0]] & ~lane_mask(l)) | (d & lane_mask(l));
    else
    begin
      k = 0;
      do begin @(posedge mclk); k++; end while (rsp_valid !== 1'b1 && k < 20);
      check("latency", 16'(RD_LAT), 16'(k));
      check("read data", ref_mem[a[7:0]] & lane_mask(l), rsp_rdata & lane_mask(l));
    end
  endtask
  // ****
  // tests
  // ****
  initial
  begin
    void'($urandom(32'hE903));
    foreach (ref_mem[i]) ref_mem[i] = 16'h0000;
    repeat (3) @(posedge mclk);
    rst <= 0;
    // every lane mix, including none, written then read back
    for (int i = 0; i < 4; i++)
      for (int l = 0; l < 8; l++)
        op(l < 4, 18'(i), 16'($urandom), l[1:0]);
    $display("lane test done");
    // back-to-back random traffic over the whole address range
    repeat (60) op(1'($urandom), 18'($urandom), 16'($urandom), 2'($urandom));
    $display("random test done");
    report_and_stop();
  end
  // about 92 requests of under 12 cycles each fit well inside this
  initial
  begin
    #50000;
    err_count++;
    report_and_stop();
  end
endmodule // testbench
